// >>> common/radio_cmd_pkg.sv
// shared constants and carrier types of the serial command and interrupt block
// assumes one core clock plus the serial clock of the host; no bus of its own
package radio_cmd_pkg;

  // command words
  localparam logic [2:0] CMD_RD_REG_TOP     = 3'h0;
  localparam logic [2:0] CMD_WR_REG_TOP     = 3'h1;
  localparam logic [7:0] CMD_RX_PAYLOAD     = 8'h61;
  localparam logic [7:0] CMD_TX_PAYLOAD     = 8'hA0;
  localparam logic [7:0] CMD_FLUSH_TX       = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX       = 8'hE2;
  localparam logic [7:0] CMD_REPEAT         = 8'hE3;
  localparam logic [7:0] CMD_ACTIVATE       = 8'h50;
  localparam logic [7:0] CMD_LEN_QUERY      = 8'h60;
  localparam logic [4:0] CMD_ACK_REPLY_TOP  = 5'h15;
  localparam logic [7:0] CMD_UNACKED        = 8'hB0;
  localparam logic [7:0] CMD_NOP            = 8'hFF;
  localparam logic [7:0] ACT_FEATURES       = 8'h73;
  localparam logic [7:0] ACT_BANK           = 8'h53;
  localparam logic [2:0] ACK_PIPE_MAX       = 3'h5;

  // register map owned here
  localparam logic [4:0] REG_CONFIG_ADDR    = 5'h00;
  localparam logic [4:0] REG_STATUS_ADDR    = 5'h07;
  localparam logic [4:0] BANK1_MSB_LAST     = 5'h08;
  localparam logic [2:0] REG_BYTES_MAX      = 3'h5;
  localparam logic [5:0] PAYLOAD_BYTES_MAX  = 6'h20;
  localparam logic [5:0] DATA_COUNT_SAT     = 6'h3F;
  localparam logic [7:0] CONFIG_RESET       = 8'h08;
  localparam logic [2:0] PIPE_RESET         = 3'h7;

  // field positions
  localparam int CFG_MASK_HI   = 6;
  localparam int CFG_MASK_LO   = 4;
  localparam int ST_FLAG_HI    = 6;
  localparam int ST_FLAG_LO    = 4;

  typedef enum logic [1:0] {TX_NORMAL, TX_UNACKED, TX_ACK_REPLY} tx_kind_t;
  typedef enum {FR_IDLE, FR_CMD, FR_DATA} frame_state_t;
  typedef enum {SRC_ZERO, SRC_REG, SRC_RX, SRC_CFG, SRC_STATUS, SRC_WIDTH} src_sel_t;

  // order matches status and mask bits 6..4
  typedef struct packed {
    logic rx_ready_flag;
    logic tx_sent_flag;
    logic retry_limit_flag;
  } flags_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bank;
    logic       msb_first;
    logic [4:0] addr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       push;
    logic       commit;
    tx_kind_t   kind;
    logic [2:0] pipe;
    logic [7:0] data;
  } tx_req_t;

endpackage : radio_cmd_pkg

// >>> core/radio_serial_command_and_irq.sv
// serial command decoder, status register and interrupt pin of the radio
// assumes a host that masters the serial link and a packet engine on clock
//
// Contract
// (RQ1) unmasked set flag drives interrupt low
// (RQ2) writing one clears flag, releases pin
// (RQ3) mask bits gate sources, clear at reset
// (RQ4) pipe field updates at interrupt fall
// (RQ5) host starts each command with select fall
// (RQ6) status shifts out during command byte
// (RQ7) command msb first, data lsb byte first
// (RQ8) bank1 regs 0-8 msb byte first
// (RQ9) register read returns up to five bytes
// (RQ10) register write only when radio idle
// (RQ11) payload read pops bytes, then releases entry
// (RQ12) payload load pushes up to 32 bytes
// (RQ13) flush command empties transmit queue
// (RQ14) flush receive empties receive queue
// (RQ15) repeat mode until load or flush
// (RQ16) host never toggles repeat mid packet
// (RQ17) activate 0x73 toggles extra commands
// (RQ18) inactive extras ignore writes, read zero
// (RQ19) activate 0x53 toggles bank, seen bank_status_register
// (RQ20) length query returns head entry width
// (RQ21) reply payload queued for pipe 0-5
// (RQ22) unacked payload marked for no ack
// (RQ23) no-operation changes nothing
// (RQ24) masks sit at config bits 6,5,4
// (RQ25) select high ends command, edges ignored
`timescale 1ns/10ps
`default_nettype none

module radio_serial_command_and_irq
  import radio_cmd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       spi_clock,
  input  wire logic       chip_select_n,
  input  wire logic       mosi,
  output var  logic       miso_out,
  output var  logic       miso_oe_n,
  output var  logic       irq_n,
  input  wire flags_t     events,
  input  wire logic [2:0] rx_head_pipe,
  input  wire logic [5:0] rx_head_width,
  input  wire logic       tx_fifo_full,
  input  wire logic       radio_active,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic [7:0] rx_data,
  output var  reg_req_t   reg_req,
  output var  tx_req_t    tx_req,
  output var  logic       rx_pop,
  output var  logic       rx_release,
  output var  logic       flush_tx,
  output var  logic       flush_rx,
  output var  logic       repeat_active,
  output var  logic [7:0] config_out,
  output var  logic       bank_sel,
  output var  logic       features_on
);

  ////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the host; select high clears it so no edge is needed after a frame
  logic [2:0] bit_cnt_ff;
  logic [6:0] sin_ff;
  logic [7:0] link_byte_ff;
  logic       link_tgl_ff;
  logic       first_ff;
  logic [7:0] tx_sh_ff;
  logic       miso_ff;
  logic [7:0] tx_hold_ff;
  logic [7:0] status_snap_ff;

  // (RQ25) select high ends frame
  always_ff @(posedge spi_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_ff   <= 3'h0;
      sin_ff       <= 7'h00;
      link_byte_ff <= 8'h00;
      link_tgl_ff  <= 1'b0;
      first_ff     <= 1'b1;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      sin_ff     <= {sin_ff[5:0], mosi};
      // (RQ7) msb first assembly
      if (bit_cnt_ff == 3'h7) begin
        link_byte_ff <= {sin_ff, mosi};
        link_tgl_ff  <= ~link_tgl_ff;
        first_ff     <= 1'b0;
      end
    end
  end

  // tx_hold and status_snap only change well clear of the edge that loads them
  always_ff @(negedge spi_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      miso_ff  <= 1'b0;
      tx_sh_ff <= 8'h00;
    end else if (bit_cnt_ff == 3'h0) begin
      miso_ff  <= tx_hold_ff[7];
      tx_sh_ff <= {tx_hold_ff[6:0], 1'b0};
    // (RQ6) status beside command
    end else if (first_ff && bit_cnt_ff == 3'h1) begin
      miso_ff  <= status_snap_ff[6];
      tx_sh_ff <= {status_snap_ff[5:0], 2'b00};
    end else begin
      miso_ff  <= tx_sh_ff[7];
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  assign miso_out = miso_ff;

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the core clock
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic tgl_s1_ff, tgl_s2_ff, tgl_seen_ff;
  logic byte_ev, frame_end;

  always_ff @(posedge clock) begin
    if (srst) begin
      cs_s1_ff  <= 1'b1;
      cs_s2_ff  <= 1'b1;
      cs_s3_ff  <= 1'b1;
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff  <= chip_select_n;
      cs_s2_ff  <= cs_s1_ff;
      cs_s3_ff  <= cs_s2_ff;
      tgl_s1_ff <= link_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
    end
  end

  // the toggle is cleared with select, so it is only trusted inside a frame
  always_ff @(posedge clock) begin
    if (srst) begin
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_seen_ff <= tgl_s2_ff;
    end
  end

  assign byte_ev   = (tgl_s2_ff != tgl_seen_ff) && !cs_s2_ff;
  assign frame_end = cs_s2_ff && !cs_s3_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= cs_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  frame_state_t state_ff;
  logic [7:0]   cmd_ff;
  logic [5:0]   dcnt_ff;
  logic         features_ff;
  logic         bank_ff;
  logic [7:0]   config_ff;
  flags_t       flags_ff;
  logic [2:0]   pipe_ff;
  logic         repeat_ff;

  logic [7:0] cur_cmd;
  logic [5:0] next_idx;
  logic [4:0] addr;
  logic       is_rd, is_wr, is_rxpl, is_txpl, is_noack, is_ack, is_len, is_cfg, is_st;
  logic       data_ev, wr_ok;
  src_sel_t   fetch_sel;

  assign cur_cmd  = (state_ff == FR_CMD) ? link_byte_ff : cmd_ff;
  assign next_idx = (state_ff == FR_CMD) ? 6'h00 : dcnt_ff + 6'h01;
  assign addr     = cur_cmd[4:0];
  assign is_rd    = cur_cmd[7:5] == CMD_RD_REG_TOP;
  assign is_wr    = cur_cmd[7:5] == CMD_WR_REG_TOP;
  assign is_rxpl  = cur_cmd == CMD_RX_PAYLOAD;
  assign is_txpl  = cur_cmd == CMD_TX_PAYLOAD;
  // (RQ18) extras dead until activated
  assign is_noack = (cur_cmd == CMD_UNACKED) && features_ff;
  assign is_ack   = (cur_cmd[7:3] == CMD_ACK_REPLY_TOP) && (cur_cmd[2:0] <= ACK_PIPE_MAX) && features_ff;
  assign is_len   = (cur_cmd == CMD_LEN_QUERY) && features_ff;
  assign is_cfg   = !bank_ff && addr == REG_CONFIG_ADDR;
  // status answers in both banks, else its bank bit could never read back as one
  assign is_st    = addr == REG_STATUS_ADDR;
  assign data_ev  = byte_ev && state_ff == FR_DATA;
  // (RQ10) writes only when radio idle
  assign wr_ok    = data_ev && is_wr && dcnt_ff < {3'h0, REG_BYTES_MAX} && !radio_active;

  // source of the next byte the host will clock out
  always_comb begin
    // (RQ23) no-op fetches only zeros
    fetch_sel = SRC_ZERO;
    // (RQ9) up to five register bytes
    if (is_rd && next_idx < {3'h0, REG_BYTES_MAX}) begin
      if (is_cfg) begin
        fetch_sel = (next_idx == 6'h00) ? SRC_CFG : SRC_ZERO;
      end else if (is_st) begin
        fetch_sel = (next_idx == 6'h00) ? SRC_STATUS : SRC_ZERO;
      end else begin
        fetch_sel = SRC_REG;
      end
    // (RQ11) payload bytes from byte 0
    end else if (is_rxpl && next_idx < PAYLOAD_BYTES_MAX) begin
      fetch_sel = SRC_RX;
    // (RQ20) head entry width
    end else if (is_len && next_idx == 6'h00) begin
      fetch_sel = SRC_WIDTH;
    end
  end

  // (RQ25) frame sequencing
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= FR_IDLE;
      cmd_ff   <= CMD_NOP;
      dcnt_ff  <= 6'h00;
    end else if (frame_end || cs_s2_ff) begin
      state_ff <= FR_IDLE;
    end else begin
      unique case (state_ff)
        FR_IDLE: begin
          state_ff <= FR_CMD;
        end
        FR_CMD: begin
          if (byte_ev) begin
            cmd_ff   <= link_byte_ff;
            dcnt_ff  <= 6'h00;
            state_ff <= FR_DATA;
          end
        end
        FR_DATA: begin
          if (byte_ev && dcnt_ff != DATA_COUNT_SAT) begin
            dcnt_ff <= dcnt_ff + 6'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: request, answer one cycle later, then hold for the link
  src_sel_t sel_ff;
  logic     load_pend_ff, load_now_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_req      <= '0;
      rx_pop       <= 1'b0;
      sel_ff       <= SRC_ZERO;
      load_pend_ff <= 1'b0;
      load_now_ff  <= 1'b0;
    end else begin
      reg_req.rd   <= byte_ev && state_ff != FR_IDLE && fetch_sel == SRC_REG;
      reg_req.wr   <= wr_ok && !is_cfg && !is_st;
      rx_pop       <= byte_ev && state_ff != FR_IDLE && fetch_sel == SRC_RX;
      load_pend_ff <= byte_ev && state_ff != FR_IDLE;
      load_now_ff  <= load_pend_ff;
      if (byte_ev) begin
        sel_ff            <= fetch_sel;
        reg_req.bank      <= bank_ff;
        reg_req.addr      <= addr;
        // (RQ8) bank1 low registers reverse bytes
        reg_req.msb_first <= bank_ff && addr <= BANK1_MSB_LAST;
        reg_req.idx       <= (state_ff == FR_CMD) ? 3'h0 : (is_wr ? dcnt_ff[2:0] : next_idx[2:0]);
        reg_req.wdata     <= link_byte_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_hold_ff <= 8'h00;
    end else if (load_now_ff) begin
      unique case (sel_ff)
        SRC_REG:    tx_hold_ff <= reg_rd_data;
        SRC_RX:     tx_hold_ff <= rx_data;
        SRC_CFG:    tx_hold_ff <= config_ff;
        // (RQ19) bank readable in reg 7 bit 7
        SRC_STATUS: tx_hold_ff <= {bank_ff, flags_ff, pipe_ff, tx_fifo_full};
        SRC_WIDTH:  tx_hold_ff <= {2'b00, rx_head_width};
        SRC_ZERO:   tx_hold_ff <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // payload queues and mode commands
  logic cmd_ev;
  assign cmd_ev = byte_ev && state_ff == FR_CMD;

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_req     <= '0;
      rx_release <= 1'b0;
      flush_tx   <= 1'b0;
      flush_rx   <= 1'b0;
    end else begin
      // (RQ12) load from byte 0, capped at 32
      tx_req.push <= data_ev && (is_txpl || is_noack || is_ack) && dcnt_ff < PAYLOAD_BYTES_MAX;
      tx_req.commit <= frame_end && state_ff == FR_DATA && dcnt_ff != 6'h00 && (is_txpl || is_noack || is_ack);
      if (data_ev) begin
        tx_req.data <= link_byte_ff;
      end
      if (data_ev || frame_end) begin
        // (RQ22) unacked marking
        tx_req.kind <= is_noack ? TX_UNACKED : (is_ack ? TX_ACK_REPLY : TX_NORMAL);
        // (RQ21) reply queued per pipe
        tx_req.pipe <= is_ack ? cur_cmd[2:0] : 3'h0;
      end
      // (RQ11) release entry after read
      rx_release <= frame_end && state_ff == FR_DATA && is_rxpl && dcnt_ff != 6'h00;
      // (RQ13) flush transmit queue
      flush_tx   <= cmd_ev && link_byte_ff == CMD_FLUSH_TX;
      // (RQ14) flush receive queue
      flush_rx   <= cmd_ev && link_byte_ff == CMD_FLUSH_RX;
    end
  end

  // (RQ15) repeat until load or flush
  always_ff @(posedge clock) begin
    if (srst) begin
      repeat_ff <= 1'b0;
    end else if (cmd_ev && link_byte_ff == CMD_FLUSH_TX) begin
      repeat_ff <= 1'b0;
    end else if (frame_end && state_ff == FR_DATA && is_txpl && dcnt_ff != 6'h00) begin
      repeat_ff <= 1'b0;
    end else if (cmd_ev && link_byte_ff == CMD_REPEAT) begin
      repeat_ff <= 1'b1;
    end
  end

  // (RQ17) activate toggles, only when idle
  always_ff @(posedge clock) begin
    if (srst) begin
      features_ff <= 1'b0;
      bank_ff     <= 1'b0;
    end else if (data_ev && cur_cmd == CMD_ACTIVATE && dcnt_ff == 6'h00 && !radio_active) begin
      if (link_byte_ff == ACT_FEATURES) begin
        features_ff <= ~features_ff;
      end
      // (RQ19) bank toggle
      if (link_byte_ff == ACT_BANK) begin
        bank_ff <= ~bank_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, status flags and interrupt pin
  flags_t mask, clr;
  assign mask = flags_t'(config_ff[CFG_MASK_HI:CFG_MASK_LO]);
  assign clr  = (wr_ok && is_st && dcnt_ff == 6'h00) ? flags_t'(link_byte_ff[ST_FLAG_HI:ST_FLAG_LO]) : flags_t'(3'h0);

  // (RQ24) masks in bits 6..4, reset clear
  always_ff @(posedge clock) begin
    if (srst) begin
      config_ff <= CONFIG_RESET;
    end else if (wr_ok && is_cfg && dcnt_ff == 6'h00) begin
      config_ff <= link_byte_ff;
    end
  end

  // (RQ2) write one clears; a new event wins
  always_ff @(posedge clock) begin
    if (srst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= flags_t'((flags_ff & ~clr) | events);
    end
  end

  // (RQ1) unmasked flags pull pin low
  // (RQ3) masks gate sources
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(flags_ff & ~mask);
    end
  end

  // (RQ4) pipe captured on the falling pin
  always_ff @(posedge clock) begin
    if (srst) begin
      pipe_ff <= PIPE_RESET;
    end else if (irq_n && |(flags_ff & ~mask)) begin
      pipe_ff <= rx_head_pipe;
    end
  end

  // frozen while a frame runs; bit 7 of the shifted copy always reads zero
  always_ff @(posedge clock) begin
    if (srst) begin
      status_snap_ff <= 8'h00;
    end else if (cs_s2_ff) begin
      status_snap_ff <= {1'b0, flags_ff, pipe_ff, tx_fifo_full};
    end
  end

  assign repeat_active = repeat_ff;
  assign config_out    = config_ff;
  assign bank_sel      = bank_ff;
  assign features_on   = features_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_irq_goes_low: assert property (@(posedge clock) disable iff (srst) // RQ1
    (|(flags_ff & ~mask)) |=> !irq_n) else $error("unmasked flag did not pull irq low");
  a_irq_clear_flag: assert property (@(posedge clock) disable iff (srst) // RQ2
    (clr.rx_ready_flag && !events.rx_ready_flag && !(|(flags_ff & ~mask & 3'b011)))
      |=> ##1 irq_n) else $error("irq not released after clear");
  a_mask_reset_zero: assert property (@(posedge clock) disable iff (srst) // RQ3
    $fell(srst) |-> config_ff[CFG_MASK_HI:CFG_MASK_LO] == 3'h0) else $error("masks not clear after reset");
  a_mask_blocks_src: assert property (@(posedge clock) disable iff (srst) // RQ24
    (|flags_ff && !(|(flags_ff & ~mask)) && config_ff[CFG_MASK_HI]) |=> irq_n) else $error("masked source drove irq");
  a_pipe_on_fall: assert property (@(posedge clock) disable iff (srst) // RQ4
    $changed(pipe_ff) |-> $fell(irq_n)) else $error("pipe field moved outside irq fall");
  a_read_idx_range: assert property (@(posedge clock) disable iff (srst) // RQ9
    reg_req.rd |-> reg_req.idx < REG_BYTES_MAX) else $error("register read past fifth byte");
  a_write_when_idle: assert property (@(posedge clock) disable iff (srst) // RQ10
    reg_req.wr |-> $past(!radio_active)) else $error("register write while radio active");
  a_push_cap_32: assert property (@(posedge clock) disable iff (srst) // RQ12
    tx_req.push |-> $past(dcnt_ff) < PAYLOAD_BYTES_MAX) else $error("payload push beyond 32 bytes");
  a_flush_ends_rep: assert property (@(posedge clock) disable iff (srst) // RQ15
    flush_tx |-> !repeat_ff) else $error("flush left repeat mode on");
  a_repeat_set: assert property (@(posedge clock) disable iff (srst) // RQ15
    (cmd_ev && link_byte_ff == CMD_REPEAT) |=> repeat_ff [*2]) else $error("repeat mode not entered");
  a_extra_gated: assert property (@(posedge clock) disable iff (srst) // RQ18
    (tx_req.push && tx_req.kind != TX_NORMAL) |-> $past(features_ff)) else $error("extra command while inactive");
  a_frame_end_idle: assert property (@(posedge clock) disable iff (srst) // RQ25
    frame_end |=> state_ff == FR_IDLE) else $error("frame not ended by select");

  c_reg_read: cover property (@(posedge clock) disable iff (srst) reg_req.rd ##[1:200] rx_release || frame_end);
  c_tx_commit: cover property (@(posedge clock) disable iff (srst) tx_req.push ##[1:400] tx_req.commit);
  c_irq_fall: cover property (@(posedge clock) disable iff (srst) $fell(irq_n));
  c_bank_toggle: cover property (@(posedge clock) disable iff (srst) $changed(bank_ff));

endmodule : radio_serial_command_and_irq

`default_nettype wire

// >>> test/radio_host_model.sv
// host model: serial master that runs one command frame at a time, mode 0
// assumes the bench calls frame() from a single process
`timescale 1ns/10ps
`default_nettype none
module radio_host_model (
  output var  logic       spi_clock,
  output var  logic       chip_select_n,
  output var  logic       mosi,
  input  wire logic       miso_out,
  input  wire logic       miso_oe_n,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_stb
);
  initial begin
    spi_clock = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // eighth high phase is stretched so the core can fetch the next byte
  task automatic frame(input logic [7:0] tx [34], input int n, input int rep);
    logic [7:0] sh;
    #3.3;
    chip_select_n = 1'b0;
    #150;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        mosi = tx[b][i];
        #7.5 spi_clock = 1'b1;
        sh[i] = miso_oe_n ? 1'bx : miso_out;
        #((i == 0) ? 250 : 7.5) spi_clock = 1'b0;
      end
      if (b < rep) begin
        rx_byte = sh;
        rx_stb = 1'b1;
        #1 rx_stb = 1'b0;
      end
    end
    #250;
    chip_select_n = 1'b1;
    mosi = ~mosi;
    #150;
  endtask : frame
endmodule : radio_host_model
`default_nettype wire

// >>> test/radio_serial_command_and_irq_bench.sv
// self-checking bench of the serial command and interrupt block
// assumes the host model drives the link; core-side partners live here
`timescale 1ns/10ps
`default_nettype none
module radio_serial_command_and_irq_bench;
  import radio_cmd_pkg::*;
  logic       clock, srst, spi_clock, chip_select_n, mosi, miso_out, miso_oe_n, irq_n, rx_stb;
  logic       tx_fifo_full, radio_active, rx_pop, rx_release, flush_tx, flush_rx;
  logic       repeat_active, bank_sel, features_on;
  logic [2:0] rx_head_pipe, ep, p;
  logic [5:0] rx_head_width;
  logic [7:0] reg_rd_data, rx_data, config_out, rx_byte, cmd;
  logic [7:0] tb [34];
  logic [7:0] exp_q [$], txq [$], kq [$], wq [$];
  flags_t     events, ef;
  reg_req_t   reg_req;
  tx_req_t    tx_req;
  int         mismatches, cmp_count, n_ftx, n_frx, n_rel, n;
  int         seed = 29885;

  radio_serial_command_and_irq dut (.clock(clock), .srst(srst), .spi_clock(spi_clock),
    .chip_select_n(chip_select_n), .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .irq_n(irq_n), .events(events), .rx_head_pipe(rx_head_pipe), .rx_head_width(rx_head_width),
    .tx_fifo_full(tx_fifo_full), .radio_active(radio_active), .reg_rd_data(reg_rd_data),
    .rx_data(rx_data), .reg_req(reg_req), .tx_req(tx_req), .rx_pop(rx_pop), .rx_release(rx_release),
    .flush_tx(flush_tx), .flush_rx(flush_rx), .repeat_active(repeat_active),
    .config_out(config_out), .bank_sel(bank_sel), .features_on(features_on));
  radio_host_model host (.spi_clock(spi_clock), .chip_select_n(chip_select_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .rx_byte(rx_byte), .rx_stb(rx_stb));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  // register map and receive queue answer one cycle after each request
  always @(posedge clock) begin
    if (reg_req.rd) reg_rd_data <= {reg_req.msb_first, reg_req.bank, reg_req.addr[2:0], reg_req.idx};
    if (reg_req.wr) chk(reg_req.wdata, wq.size() ? wq.pop_front() : 8'hXX);
    if (rx_pop) rx_data <= rx_data + 8'h11;
    n_ftx <= n_ftx + flush_tx;
    n_frx <= n_frx + flush_rx;
    n_rel <= n_rel + rx_release;
    if (tx_req.push) chk(tx_req.data, txq.size() ? txq.pop_front() : 8'hXX);
    if (tx_req.commit) chk({3'h0, tx_req.kind, tx_req.kind == TX_ACK_REPLY ? tx_req.pipe : 3'h0},
      kq.size() ? kq.pop_front() : 8'hXX);
  end
  always @(posedge rx_stb) chk(rx_byte, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] st();
    return {1'b0, ef, ep, tx_fifo_full};
  endfunction : st
  // status byte always leads the expected bytes of a frame
  task automatic go(input logic [7:0] c, input logic [7:0] d, input int len, input int rep);
    tb[0] = c;
    if (len == 2) tb[1] = d;
    exp_q.push_front(st());
    host.frame(tb, len, rep);
    repeat (4) @(posedge clock);
  endtask : go
  task automatic wait_irq(input logic v);
    int k;
    for (k = 0; k < 40 && irq_n !== v; k++) @(posedge clock);
    chk({7'h00, irq_n}, {7'h00, v});
    if (k == 40) wrap_up();
  endtask : wait_irq
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1; events = '0; rx_head_pipe = 3'h0; rx_head_width = 6'h01; radio_active = 1'b0;
    tx_fifo_full = 1'b0; reg_rd_data = 8'h00; rx_data = 8'h00; ef = '0; ep = PIPE_RESET;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    tx_fifo_full <= 1'($random(seed));
    repeat (3) @(posedge clock);
    chk(config_out, CONFIG_RESET);
    chk({5'h00, irq_n, bank_sel, features_on}, 8'h04);
    chk({7'h00, repeat_active}, 8'h00);
    go(CMD_NOP, 8'h00, 1, 1);
    note("reset");
    for (int s = 0; s < 3; s++) begin
      ep = 3'($random(seed));
      rx_head_pipe <= ep;
      @(posedge clock);
      events <= flags_t'(3'h4 >> s);
      @(posedge clock);
      events <= '0;
      wait_irq(1'b0);
      ef = flags_t'(3'h4 >> s);
      go(8'h27, {1'b0, ef, 4'h0}, 2, 1);
      ef = '0;
      wait_irq(1'b1);
    end
    go(8'h20, 8'h78, 2, 1);
    chk(config_out, 8'h78);
    exp_q.push_back(8'h78);
    go(8'h00, 8'h00, 2, 2);
    events <= '1;
    @(posedge clock);
    events <= '0;
    ef = '1;
    repeat (8) @(posedge clock);
    chk({7'h00, irq_n}, 8'h01);
    go(8'h27, 8'h70, 2, 1);
    ef = '0;
    radio_active <= 1'b1;
    go(8'h20, 8'h08, 2, 1);
    chk(config_out, 8'h78);
    go(8'h23, 8'h5A, 2, 1);
    radio_active <= 1'b0;
    wq.push_back(8'hC3);
    go(8'h23, 8'hC3, 2, 1);
    go(8'h20, 8'h08, 2, 1);
    chk(config_out, 8'h08);
    note("irq");
    for (int i = 0; i < 5; i++) exp_q.push_back({5'h03, 3'(i)});
    exp_q.push_back(8'h00);
    go(8'h03, 8'h00, 7, 7);
    go(CMD_ACTIVATE, ACT_BANK, 2, 1);
    chk({7'h00, bank_sel}, 8'h01);
    for (int i = 0; i < 2; i++) exp_q.push_back({5'h1A, 3'(i)});
    go(8'h02, 8'h00, 3, 3);
    for (int i = 0; i < 2; i++) exp_q.push_back({5'h09, 3'(i)});
    go(8'h09, 8'h00, 3, 3);
    exp_q.push_back({1'b1, ef, ep, tx_fifo_full});
    go(8'h07, 8'h00, 2, 2);
    go(CMD_ACTIVATE, ACT_BANK, 2, 1);
    chk({7'h00, bank_sel}, 8'h00);
    note("registers");
    rx_head_width <= 6'(1 + {$random(seed)} % 32);
    exp_q.push_back(8'h00);
    go(CMD_LEN_QUERY, 8'h00, 2, 2);
    go(CMD_UNACKED, 8'h5A, 2, 1);
    go(CMD_ACTIVATE, ACT_FEATURES, 2, 1);
    chk({7'h00, features_on}, 8'h01);
    exp_q.push_back({2'b00, rx_head_width});
    go(CMD_LEN_QUERY, 8'h00, 2, 2);
    note("features");
    go(CMD_REPEAT, 8'h00, 1, 1);
    chk({7'h00, repeat_active}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 33 : 1 + {$random(seed)} % 32;
      p = 3'({$random(seed)} % 6);
      for (int i = 1; i <= n; i++) begin
        tb[i] = 8'($random(seed));
        if (i <= 32) txq.push_back(tb[i]);
      end
      cmd = (k == 0) ? CMD_TX_PAYLOAD : (k == 1) ? CMD_UNACKED : {CMD_ACK_REPLY_TOP, p};
      kq.push_back({3'h0, 2'(k), k == 2 ? p : 3'h0});
      go(cmd, tb[1], n + 1, 1);
      if (k == 0) chk({7'h00, repeat_active}, 8'h00);
    end
    go(CMD_REPEAT, 8'h00, 1, 1);
    go(CMD_FLUSH_TX, 8'h00, 1, 1);
    chk({repeat_active, 7'(n_ftx)}, 8'h01);
    go(CMD_FLUSH_RX, 8'h00, 1, 1);
    chk(8'(n_frx), 8'h01);
    for (int i = 1; i <= 3; i++) exp_q.push_back(8'(8'h11 * i));
    go(CMD_RX_PAYLOAD, 8'h00, 4, 4);
    chk(8'(n_rel), 8'h01);
    chk(8'(txq.size() + exp_q.size() + kq.size() + wq.size()), 8'h00);
    note("payloads");
    wrap_up();
  end
endmodule : radio_serial_command_and_irq_bench
`default_nettype wire
